// >>> wioc_params.svh
// constants for the wireless io extension control block
`ifndef WIOC_PARAMS_SVH
`define WIOC_PARAMS_SVH

`define WIOC_CLK_MHZ 100
`define WIOC_CH 8
`define WIOC_NUM_EXT 8
`define WIOC_CODE_MIN 4'h1
`define WIOC_CODE_MAX 4'h8
`define WIOC_BOOT_CYC 3'h4

// times in ms, cycle counts derived from the clock rate
`define WIOC_BLINK_HALF_MS 250
`define WIOC_BLINK_HALF_CYC (`WIOC_BLINK_HALF_MS * 1000 * `WIOC_CLK_MHZ)
`define WIOC_LOSS_MS 1000
`define WIOC_LOSS_CYC (`WIOC_LOSS_MS * 1000 * `WIOC_CLK_MHZ)
`define WIOC_TX_PERIOD_MS 100
`define WIOC_TX_PERIOD_CYC (`WIOC_TX_PERIOD_MS * 1000 * `WIOC_CLK_MHZ)

// register offsets
`define WIOC_REG_STATUS 8'h00
`define WIOC_REG_MASK 8'h04
`define WIOC_REG_CTRL 8'h08
`define WIOC_REG_STATE 8'h0c
`define WIOC_REG_IO 8'h10

// status / mask bit positions
`define WIOC_EV_FOUND 0
`define WIOC_EV_LOST 1
`define WIOC_EV_CFGERR 2
`define WIOC_EV_INCHG 3
`define WIOC_EV_W 4

// control bits and reset value
`define WIOC_CTRL_OUT_EN 0
`define WIOC_CTRL_TX_EN 1
`define WIOC_CTRL_RST 2'h3

`endif

// >>> wioc_pkg.sv
// types shared by the wireless io extension control block
`include "wioc_params.svh"
package wioc_pkg;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_SEARCH,
    ST_LINKED,
    ST_ERROR
  } wioc_state_e;

  typedef struct packed {
    wioc_state_e st;
    logic [2:0] boot_cnt;
    logic [3:0] code;
    logic is_sense;
    logic [`WIOC_CH-1:0] inp;
    logic [`WIOC_CH-1:0] relay;
    logic [31:0] loss_cnt;
    logic [31:0] tx_cnt;
    logic tx_pend;
    logic [`WIOC_CH-1:0] tx_data;
    logic [`WIOC_EV_W-1:0] sts;
    logic [`WIOC_EV_W-1:0] mask;
    logic [1:0] ctrl;
    logic [31:0] rdata;
    logic irq;
  } wioc_main_s;

endpackage

// >>> wioc_led_if.sv
// status indicator request from the control core to the blinker
`timescale 1ns/1ps
interface wioc_led_if;
  logic linked;
  logic fault;
  logic seek;
  modport core (output linked, output fault, output seek);
  modport blk (input linked, input fault, input seek);
endinterface

// >>> wioc_sync.sv
// two-stage synchroniser for a bus of independent pin levels
`timescale 1ns/1ps
module wioc_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } wioc_sync_s;

  wioc_sync_s s_r;
  wioc_sync_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (ce_i) begin
      s_nxt.meta = d_i;
      s_nxt.q = s_r.meta;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.q;
endmodule

// >>> wioc_blink.sv
// status indicator driver: steady, blinking or dark
`timescale 1ns/1ps
`include "wioc_params.svh"
module wioc_blink #(
  parameter int unsigned HALF_CYC = `WIOC_BLINK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  wioc_led_if.blk req,
  output logic led_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic phase;
    logic led;
  } wioc_blink_s;

  wioc_blink_s s_r;
  wioc_blink_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (ce_i) begin
      if (s_r.cnt >= HALF_CYC - 1) begin
        s_nxt.cnt = '0;
        s_nxt.phase = ~s_r.phase;
      end else begin
        s_nxt.cnt = s_r.cnt + 32'h1;
      end
      if (req.fault) begin
        s_nxt.led = s_r.phase; // RULE7
      end else if (req.linked) begin
        s_nxt.led = 1'b1; // RULE4
      end else if (req.seek) begin
        s_nxt.led = s_r.phase; // RULE5
      end else begin
        s_nxt.led = 1'b0; // RULE6
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign led_o = s_r.led;
endmodule

// >>> wioc_top.sv
// control core of the eight-channel wireless sensing / relay extension module
// What this block does
// RULE1: the module reads a pairing code 1 to 8 from its selector switch to pick its partner.
// RULE2: states pass between sensing and relay ends only when both carry the same pairing code.
// RULE3: at most eight extension modules per system, so only codes 1 to 8 are accepted.
// RULE4: the status indicator is lit steadily while the link is up and the partner is reachable.
// RULE5: a sensing module blinks its status indicator while no matching relay module is found.
// RULE6: a relay module keeps its status indicator dark while no matching sensing module is found.
// RULE7: a configuration error, such as analog channels paired to this digital module, blinks the indicator.
// RULE8: the pairing code is sampled only after power-up; later switch changes are ignored.
// RULE9: the sensing module lights indicator n while input n is active.
// RULE10: the relay module lights indicator n while relay output n is closed.
// RULE11: on link loss each relay output opens or holds its last state, as its own selection says.
// RULE12: each sensed input n is reproduced on relay output n of the paired module.
// RULE13: when the link returns, relay outputs follow newly received states again.
`timescale 1ns/1ps
`include "wioc_params.svh"
module wioc_top
  import wioc_pkg::*;
#(
  parameter int unsigned LOSS_CYC = `WIOC_LOSS_CYC,
  parameter int unsigned TX_PERIOD_CYC = `WIOC_TX_PERIOD_CYC,
  parameter int unsigned BLINK_HALF_CYC = `WIOC_BLINK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic role_sense_i,
  input wire logic [3:0] code_sw_i,
  input wire logic [7:0] sense_in_i,
  input wire logic [7:0] hold_sel_i,
  input wire logic link_up_i,
  input wire logic rx_valid_i,
  input wire logic [3:0] rx_code_i,
  input wire logic rx_analog_i,
  input wire logic rx_from_sense_i,
  input wire logic [7:0] rx_data_i,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [3:0] tx_code_o,
  output logic tx_analog_o,
  output logic tx_from_sense_o,
  output logic [7:0] tx_data_o,
  output logic [7:0] relay_o,
  output logic [7:0] chan_led_o,
  output logic status_led_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [20:0] pins_raw;
  logic [20:0] pins;
  logic role_s;
  logic [3:0] code_s;
  logic [7:0] sense_s;
  logic [7:0] hold_s;
  logic link_s;
  logic [7:0] keep_mask;
  wioc_main_s s_r;
  wioc_main_s s_nxt;
  wioc_led_if led_req();

  // reset asserted at once, released through two flip-flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign pins_raw = {role_sense_i, code_sw_i, sense_in_i, hold_sel_i};

  wioc_sync #(
    .W(21)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  wioc_sync #(
    .W(1)
  ) u_link_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .d_i(link_up_i),
    .q_o(link_s)
  );

  assign role_s = pins[20];
  assign code_s = pins[19:16];
  assign sense_s = pins[15:8];
  assign hold_s = pins[7:0];

  // codes beyond the number of extensions a system carries are invalid
  function automatic logic code_ok(input logic [3:0] c);
    code_ok = (c >= `WIOC_CODE_MIN) && (c <= `WIOC_CODE_MAX); // RULE1 RULE3
  endfunction

  // a frame for us carries our code and comes from the opposite role
  function automatic logic frame_ours(input logic [3:0] c, input logic [3:0] mine,
                                      input logic from_sense, input logic me_sense);
    frame_ours = (c == mine) && (from_sense != me_sense); // RULE2
  endfunction

  // per-channel choice between dropping and holding on link loss
  genvar g;
  generate
    for (g = 0; g < `WIOC_CH; g++) begin : g_keep
      assign keep_mask[g] = hold_s[g] & s_r.relay[g]; // RULE11
    end
  endgenerate

  always_comb begin
    logic rx_hit;
    logic lost;
    logic [`WIOC_EV_W-1:0] ev;
    rx_hit = 1'b0;
    lost = 1'b0;
    ev = '0;
    s_nxt = s_r;
    if (ce_i) begin
      rx_hit = rx_valid_i && frame_ours(rx_code_i, s_r.code, rx_from_sense_i, s_r.is_sense);
      if (s_r.is_sense) begin
        s_nxt.inp = sense_s; // RULE9
        if (sense_s != s_r.inp) begin
          ev[`WIOC_EV_INCHG] = 1'b1;
        end
      end
      case (s_r.st)
        ST_BOOT: begin
          if (s_r.boot_cnt == `WIOC_BOOT_CYC) begin
            s_nxt.code = code_s; // RULE8
            s_nxt.is_sense = role_s;
            if (code_ok(code_s)) begin
              s_nxt.st = ST_SEARCH;
            end else begin
              s_nxt.st = ST_ERROR; // RULE7
              ev[`WIOC_EV_CFGERR] = 1'b1;
            end
          end else begin
            s_nxt.boot_cnt = s_r.boot_cnt + 3'h1;
          end
        end
        ST_SEARCH: begin
          if (rx_hit && rx_analog_i) begin
            s_nxt.st = ST_ERROR; // RULE7
            ev[`WIOC_EV_CFGERR] = 1'b1;
          end else if (rx_hit && link_s) begin
            s_nxt.st = ST_LINKED; // RULE4
            s_nxt.loss_cnt = '0;
            ev[`WIOC_EV_FOUND] = 1'b1;
            if (!s_r.is_sense) begin
              s_nxt.relay = rx_data_i; // RULE12 RULE13
            end
          end
        end
        ST_LINKED: begin
          if (rx_hit && rx_analog_i) begin
            s_nxt.st = ST_ERROR; // RULE7
            ev[`WIOC_EV_CFGERR] = 1'b1;
          end else if (!link_s) begin
            lost = 1'b1;
          end else if (rx_hit) begin
            // a frame in the timeout cycle still refreshes the link
            s_nxt.loss_cnt = '0;
            if (!s_r.is_sense) begin
              s_nxt.relay = rx_data_i; // RULE12
            end
          end else if (s_r.loss_cnt >= LOSS_CYC - 1) begin
            lost = 1'b1;
          end else begin
            s_nxt.loss_cnt = s_r.loss_cnt + 32'h1;
          end
          if (lost) begin
            s_nxt.st = ST_SEARCH;
            ev[`WIOC_EV_LOST] = 1'b1;
            s_nxt.relay = keep_mask; // RULE11
          end
        end
        ST_ERROR: begin
          s_nxt.relay = '0;
        end
        default: begin
          s_nxt.st = ST_BOOT;
        end
      endcase

      // periodic frame: input states from the sensing end, presence from the relay end
      // a pending frame always finishes its handshake, even after a fall into error
      if (s_r.tx_pend) begin
        if (tx_ready_i) begin
          s_nxt.tx_pend = 1'b0;
        end
      end else if (s_r.st != ST_BOOT && s_r.st != ST_ERROR) begin
        if (s_r.ctrl[`WIOC_CTRL_TX_EN] &&
            (s_r.tx_cnt >= TX_PERIOD_CYC - 1 || ev[`WIOC_EV_INCHG])) begin
          s_nxt.tx_pend = 1'b1;
          s_nxt.tx_cnt = '0;
          s_nxt.tx_data = s_r.is_sense ? sense_s : 8'h00; // RULE12
        end else begin
          s_nxt.tx_cnt = s_r.tx_cnt + 32'h1;
        end
      end

      // register port
      s_nxt.rdata = '0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `WIOC_REG_STATUS: s_nxt.rdata = 32'(s_r.sts);
          `WIOC_REG_MASK: s_nxt.rdata = 32'(s_r.mask);
          `WIOC_REG_CTRL: s_nxt.rdata = 32'(s_r.ctrl);
          `WIOC_REG_STATE: s_nxt.rdata = {22'h0, link_s, s_r.is_sense, s_r.code, s_r.st, 2'h0};
          `WIOC_REG_IO: s_nxt.rdata = {16'h0, s_r.relay, s_r.inp};
          default: s_nxt.rdata = '0;
        endcase
      end
      // set wins over a write-one clear in the same cycle
      if (reg_wr_i && reg_addr_i == `WIOC_REG_STATUS) begin
        s_nxt.sts = (s_r.sts & ~reg_wdata_i[`WIOC_EV_W-1:0]) | ev;
      end else begin
        s_nxt.sts = s_r.sts | ev;
      end
      if (reg_wr_i && reg_addr_i == `WIOC_REG_MASK) begin
        s_nxt.mask = reg_wdata_i[`WIOC_EV_W-1:0];
      end
      if (reg_wr_i && reg_addr_i == `WIOC_REG_CTRL) begin
        s_nxt.ctrl = reg_wdata_i[1:0];
      end
      s_nxt.irq = |(s_nxt.sts & s_nxt.mask);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: ST_BOOT, ctrl: `WIOC_CTRL_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign led_req.linked = (s_r.st == ST_LINKED);
  assign led_req.fault = (s_r.st == ST_ERROR);
  assign led_req.seek = (s_r.st == ST_SEARCH) && s_r.is_sense;

  wioc_blink #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) u_blink (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .req(led_req),
    .led_o(status_led_o)
  );

  assign tx_valid_o = s_r.tx_pend;
  assign tx_code_o = s_r.code;
  assign tx_analog_o = 1'b0;
  assign tx_from_sense_o = s_r.is_sense;
  assign tx_data_o = s_r.tx_data;
  assign relay_o = s_r.is_sense ? 8'h00 : (s_r.relay & {8{s_r.ctrl[`WIOC_CTRL_OUT_EN]}});
  assign chan_led_o = s_r.is_sense ? s_r.inp : relay_o; // RULE9 RULE10
  assign reg_rdata_o = s_r.rdata;
  assign irq_o = s_r.irq;
endmodule

// >>> wioc_top_assertions.sv
// port assertions for the wireless io extension control top
`timescale 1ns/1ps
module wioc_top_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_analog_o,
  input wire logic [3:0] tx_code_o,
  input wire logic tx_from_sense_o,
  input wire logic [7:0] relay_o,
  input wire logic [7:0] chan_led_o,
  input wire logic [7:0] hold_sel_i,
  input wire logic link_up_i,
  input wire logic rx_valid_i,
  input wire logic [3:0] rx_code_i,
  input wire logic rx_analog_i,
  input wire logic rx_from_sense_i,
  input wire logic [7:0] rx_data_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_tx_wait;
    tx_valid_o && !tx_ready_i;
  endsequence
  sequence s_rx_match;
    link_up_i [*4] ##0 rx_valid_i && !rx_analog_i && rx_from_sense_i && !tx_from_sense_o
      && rx_code_i == tx_code_o && tx_code_o inside {[4'h1:4'h8]};
  endsequence
  sequence s_link_gone;
    (!link_up_i && $stable(hold_sel_i)) [*4];
  endsequence
  property p_rd_stand;
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0;
  endproperty
  property p_tx_hold;
    s_tx_wait |=> tx_valid_o && $stable(tx_data_o);
  endproperty
  property p_tx_drop;
    tx_valid_o && tx_ready_i |=> !tx_valid_o;
  endproperty
  property p_digital;
    tx_analog_o == 1'b0;
  endproperty
  property p_chan_led;
    relay_o != 8'h0 |-> chan_led_o == relay_o;
  endproperty
  property p_rx_copy;
    s_rx_match |=> relay_o == $past(rx_data_i);
  endproperty
  property p_code_keep;
    tx_code_o != 4'h0 |=> $stable(tx_code_o);
  endproperty
  property p_sense_dry;
    tx_from_sense_o |-> relay_o == 8'h0;
  endproperty
  property p_relay_tx0;
    tx_valid_o && !tx_from_sense_o |-> tx_data_o == 8'h0;
  endproperty
  property p_drop;
    s_link_gone |-> (relay_o & ~hold_sel_i) == 8'h0;
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data outside its cycle");
  a_tx_hold: assert property (p_tx_hold) else $error("tx frame changed while waiting");
  a_tx_drop: assert property (p_tx_drop) else $error("tx valid kept after accept");
  a_digital: assert property (p_digital) else $error("frame marked analog");
  a_chan_led: assert property (p_chan_led) else $error("channel led differs from relay");
  a_rx_copy: assert property (p_rx_copy) else $error("relay not copied from frame");
  a_code_keep: assert property (p_code_keep) else $error("captured code moved");
  a_sense_dry: assert property (p_sense_dry) else $error("sensing module drives relay");
  a_relay_tx0: assert property (p_relay_tx0) else $error("relay frame carries data");
  a_drop: assert property (p_drop) else $error("relay kept without hold");
endmodule
bind wioc_top wioc_top_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
  .tx_analog_o(tx_analog_o), .tx_code_o(tx_code_o), .tx_from_sense_o(tx_from_sense_o), .relay_o(relay_o),
  .chan_led_o(chan_led_o), .hold_sel_i(hold_sel_i), .link_up_i(link_up_i), .rx_valid_i(rx_valid_i),
  .rx_code_i(rx_code_i), .rx_analog_i(rx_analog_i), .rx_from_sense_i(rx_from_sense_i), .rx_data_i(rx_data_i));

// >>> wioc_xcvr_model.sv
// transceiver model: random tx stall, rx frames on request
`timescale 1ns/1ps
module wioc_xcvr_model (
  input wire logic clk_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [3:0] rx_code_o,
  output logic rx_analog_o,
  output logic rx_from_sense_o,
  output logic [7:0] rx_data_o
);
  logic [7:0] got_q[$];
  initial begin
    {tx_ready_o, rx_valid_o, rx_code_o, rx_analog_o, rx_from_sense_o, rx_data_o} = 16'h0;
  end
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_q.push_back(tx_data_i);
    end
    tx_ready_o <= tx_valid_i && !tx_ready_o && ($urandom_range(3) == 0);
  end
  // idle bus shows the inverse of the last frame
  task automatic send(input logic [3:0] c, input logic an, input logic fs, input logic [7:0] dt);
    @(posedge clk_i);
    {rx_valid_o, rx_code_o, rx_analog_o, rx_from_sense_o, rx_data_o} <= {1'b1, c, an, fs, dt};
    @(posedge clk_i);
    {rx_valid_o, rx_code_o, rx_analog_o, rx_from_sense_o, rx_data_o} <= {1'b0, ~c, ~an, ~fs, ~dt};
  endtask
endmodule

// >>> wioc_tb_top.sv
// self-checking bench of the wireless io extension control top
`timescale 1ns/1ps
`include "wioc_params.svh"
module wioc_tb_top;
  logic clk_i = 0, rst_n_i = 0, role_sense_i = 0, link_up_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [3:0] code_sw_i = 4'h3, rx_code_i, tx_code_o;
  logic [7:0] sense_in_i = 8'h0, hold_sel_i = 8'h0, reg_addr_i = 8'h0, rx_data_i, tx_data_o, relay_o, chan_led_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
  logic rx_valid_i, rx_analog_i, rx_from_sense_i, tx_ready_i, tx_valid_o, tx_analog_o, tx_from_sense_o;
  logic status_led_o, irq_o;
  logic [7:0] dt, hold, exp_q[$];
  int failures = 0, checks_done = 0, i, tg;
  always #5 clk_i = ~clk_i;
  wioc_top #(.LOSS_CYC(40), .TX_PERIOD_CYC(8), .BLINK_HALF_CYC(4)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ce_i(1'b1), .role_sense_i(role_sense_i), .code_sw_i(code_sw_i), .sense_in_i(sense_in_i),
    .hold_sel_i(hold_sel_i), .link_up_i(link_up_i), .rx_valid_i(rx_valid_i), .rx_code_i(rx_code_i),
    .rx_analog_i(rx_analog_i), .rx_from_sense_i(rx_from_sense_i), .rx_data_i(rx_data_i),
    .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o), .tx_code_o(tx_code_o), .tx_analog_o(tx_analog_o),
    .tx_from_sense_o(tx_from_sense_o), .tx_data_o(tx_data_o), .relay_o(relay_o), .chan_led_o(chan_led_o),
    .status_led_o(status_led_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  wioc_xcvr_model u_x (.clk_i(clk_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i),
    .rx_valid_o(rx_valid_i), .rx_code_o(rx_code_i), .rx_analog_o(rx_analog_i),
    .rx_from_sense_o(rx_from_sense_i), .rx_data_o(rx_data_i));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic boot(input logic rs, input logic [3:0] c);
    @(posedge clk_i);
    {rst_n_i, role_sense_i, code_sw_i, link_up_i} <= {1'b0, rs, c, 1'b0};
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    link_up_i <= 1'b1;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic blinks(output int n);
    logic p;
    n = 0;
    p = status_led_o;
    repeat (24) begin
      @(posedge clk_i);
      #1 n += (status_led_o !== p);
      p = status_led_o;
    end
  endtask
  initial begin
    #200000;
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(32'hacf2f515));
    boot(1'b0, 4'h3);
    u_x.send(4'h4, 1'b0, 1'b1, 8'hff);
    u_x.send(4'h3, 1'b0, 1'b0, 8'hff);
    #1 chk("relay_ignored", 32'h0, relay_o);
    for (i = 0; i < 6; i++) begin
      dt = $urandom;
      exp_q.push_back(dt);
      u_x.send(4'h3, 1'b0, 1'b1, dt);
      #1 chk("relay", exp_q[$], relay_o);
      chk("chan_led", exp_q[$], chan_led_o);
    end
    @(posedge clk_i);
    #1 chk("status_on", 32'h1, status_led_o);
    chk("irq_masked", 32'h0, irq_o);
    wr(`WIOC_REG_MASK, 32'h1);
    #1 chk("irq_on", 32'h1, irq_o);
    wr(`WIOC_REG_STATUS, 32'h1);
    #1 chk("irq_clr", 32'h0, irq_o);
    rd(`WIOC_REG_IO, d);
    chk("io_relay", exp_q[$], d[15:8]);
    rd(8'h40, d);
    chk("unmapped", 32'h0, d);
    code_sw_i <= 4'h5;
    repeat (8) @(posedge clk_i);
    rd(`WIOC_REG_STATE, d);
    chk("state_code", {4'h3, 2'h2}, d[7:2]);
    hold = $urandom;
    hold_sel_i <= hold;
    dt = $urandom;
    repeat (4) @(posedge clk_i);
    u_x.send(4'h3, 1'b0, 1'b1, dt);
    link_up_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1 chk("relay_loss", dt & hold, relay_o);
    blinks(tg);
    chk("status_dark", 32'h0, {31'(tg), status_led_o});
    link_up_i <= 1'b1;
    dt = ~dt;
    repeat (5) @(posedge clk_i);
    u_x.send(4'h3, 1'b0, 1'b1, dt);
    #1 chk("relay_back", dt, relay_o);
    // analog frame with our code: coding error, relays open one cycle later
    u_x.send(4'h3, 1'b1, 1'b1, dt);
    @(posedge clk_i);
    #1 chk("relay_cfgerr", 32'h0, relay_o);
    rd(`WIOC_REG_STATUS, d);
    chk("sts_events", 32'h7, d);
    boot(1'b1, 4'h5);
    dt = $urandom;
    sense_in_i <= dt;
    u_x.got_q.delete();
    repeat (6) @(posedge clk_i);
    #1 chk("in_led", dt, chan_led_o);
    rd(`WIOC_REG_STATUS, d);
    chk("sts_inchg", (dt != 8'h0) ? 32'h8 : 32'h0, d);
    for (i = 0; i < 200 && (u_x.got_q.size() < 3); i++) begin
      @(posedge clk_i);
    end
    if (u_x.got_q.size() < 3) begin
      failures++;
      close_out();
    end
    chk("tx_data", dt, u_x.got_q[$]);
    blinks(tg);
    chk("seek_blink", 32'h1, tg >= 2);
    boot(1'b0, 4'h9);
    blinks(tg);
    chk("err_blink", 32'h1, tg >= 2);
    rd(`WIOC_REG_STATE, d);
    chk("err_state", 32'h3, d[3:2]);
    close_out();
  end
endmodule
